// ===== hw/pcldc_dev.sv
/*
 Control logic of the six-channel LED driver: enable and shutdown
 timing, pulse-count current codes, pump mode sequencing, protection.
 Assumes the link lines are asynchronous and the analog side reports
 regulation, temperature, undervoltage and tied channels as levels.
*/
`timescale 1ns/1ps
module pcldc_dev #(
   parameter int OFF_CYC       = pcldc_pkg::OFF_CYC,
   parameter int QUAL_CYC      = pcldc_pkg::QUAL_CYC,
   parameter int PUMP_HALF_CYC = pcldc_pkg::PUMP_HALF_CYC
) (
   input  wire logic                         i_ref_clk,
   input  wire logic                         i_srst,
   pcldc_if.dev                              link,
   input  wire logic                         i_regulation_ok,
   input  wire logic                         i_die_hot,
   input  wire logic                         i_die_cooled,
   input  wire logic                         i_uvlo,
   input  wire logic [pcldc_pkg::MAIN_CH-1:0] i_main_tied,
   input  wire logic [pcldc_pkg::SUB_CH-1:0]  i_sub_tied,
   output logic [pcldc_pkg::CODE_W-1:0]       o_main_code,
   output logic [pcldc_pkg::CODE_W-1:0]       o_sub_code,
   output logic [pcldc_pkg::MAIN_CH-1:0]      o_main_on,
   output logic [pcldc_pkg::SUB_CH-1:0]       o_sub_on,
   output logic                               o_pump_boost,
   output logic                               o_pump_clk,
   output logic                               o_shutdown
);

   function automatic logic [pcldc_pkg::CODE_W-1:0] step_code(input logic [pcldc_pkg::CODE_W-1:0] c);
      // Zero wraps to full scale, which also makes the first edge full scale
      if (c == pcldc_pkg::CODE_OFF) begin
         step_code = pcldc_pkg::CODE_FULL;
      end else begin
         step_code = c - 5'h01;
      end
   endfunction

   logic [2:0]                        sync1_q;
   logic [2:0]                        sync2_q;
   logic [2:0]                        prev_q;
   logic [pcldc_pkg::TIMER_W-1:0]     off_cnt_q;
   logic [pcldc_pkg::TIMER_W-1:0]     off_cnt_d;
   logic                              shut_q;
   logic                              shut_d;
   logic                              therm_q;
   logic [pcldc_pkg::CODE_W-1:0]      main_code_q;
   logic [pcldc_pkg::CODE_W-1:0]      main_code_d;
   logic [pcldc_pkg::CODE_W-1:0]      sub_code_q;
   logic [pcldc_pkg::CODE_W-1:0]      sub_code_d;
   pcldc_pkg::pcldc_pump_t            pump_q;
   pcldc_pkg::pcldc_pump_t            pump_d;
   logic [pcldc_pkg::TIMER_W-1:0]     qual_cnt_q;
   logic [pcldc_pkg::TIMER_W-1:0]     qual_cnt_d;
   logic [pcldc_pkg::TIMER_W-1:0]     sw_cnt_q;
   logic [pcldc_pkg::TIMER_W-1:0]     sw_cnt_d;
   logic                              pump_clk_q;
   logic                              pump_clk_d;
   logic                              boost_q;
   logic [pcldc_pkg::MAIN_CH-1:0]     main_on_q;
   logic [pcldc_pkg::SUB_CH-1:0]      sub_on_q;

   wire [2:0] line_raw = {link.sub_dim_pulse_n, link.main_dim_pulse_n, link.en};
   wire       en_now   = sync2_q[pcldc_pkg::LN_EN];
   // Edges qualified by the enable seen one sample earlier, so a single
   // tied line still counts its own falling edge
   wire       en_was   = prev_q[pcldc_pkg::LN_EN];
   wire       dim_ok   = en_was & ~shut_q;
   wire       main_fall = dim_ok & prev_q[pcldc_pkg::LN_MAIN]
                          & ~sync2_q[pcldc_pkg::LN_MAIN];
   wire       sub_fall  = dim_ok & prev_q[pcldc_pkg::LN_SUB]
                          & ~sync2_q[pcldc_pkg::LN_SUB];
   wire       off_hit  = ~en_now & (off_cnt_q == OFF_CYC[pcldc_pkg::TIMER_W-1:0] - 17'h00001);
   wire       active   = ~shut_q & ~therm_q & ~i_uvlo;
   wire       qual_hit = (qual_cnt_q == QUAL_CYC[pcldc_pkg::TIMER_W-1:0] - 17'h00001);
   wire       sw_hit   = (sw_cnt_q == PUMP_HALF_CYC[pcldc_pkg::TIMER_W-1:0] - 17'h00001);

   // Two flops before any logic reads the pins
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         sync1_q <= pcldc_pkg::LINE_IDLE;
         sync2_q <= pcldc_pkg::LINE_IDLE;
         prev_q  <= pcldc_pkg::LINE_IDLE;
      end else begin
         sync1_q <= line_raw;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // Enable low time; a high sample restarts it
   always_comb begin
      if (en_now) begin
         off_cnt_d = '0;
      end else if (off_hit) begin
         off_cnt_d = off_cnt_q;
      end else begin
         off_cnt_d = off_cnt_q + 17'h00001;
      end
   end

   always_comb begin
      if (shut_q) begin
         shut_d = ~en_now;
      end else begin
         shut_d = off_hit;
      end
   end

   always_comb begin
      main_code_d = main_code_q;
      sub_code_d  = sub_code_q;
      if (shut_q) begin
         main_code_d = pcldc_pkg::CODE_OFF;
         sub_code_d  = pcldc_pkg::CODE_OFF;
      end else begin
         if (main_fall) begin
            main_code_d = step_code(main_code_q);
         end
         if (sub_fall) begin
            sub_code_d = step_code(sub_code_q);
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         off_cnt_q   <= '0;
         shut_q      <= 1'b1;
         main_code_q <= pcldc_pkg::CODE_OFF;
         sub_code_q  <= pcldc_pkg::CODE_OFF;
      end else begin
         off_cnt_q   <= off_cnt_d;
         shut_q      <= shut_d;
         main_code_q <= main_code_d;
         sub_code_q  <= sub_code_d;
      end
   end

   // Hysteresis lives in the two comparators; hot wins if both assert
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         therm_q <= 1'b0;
      end else if (i_die_hot) begin
         therm_q <= 1'b1;
      end else if (i_die_cooled) begin
         therm_q <= 1'b0;
      end
   end

   // Pump mode: off until active, then unity, boost after qualification
   always_comb begin
      pump_d = pump_q;
      unique case (pump_q)
         pcldc_pkg::PUMP_OFF: begin
            if (active) begin
               pump_d = pcldc_pkg::PUMP_UNITY;
            end
         end
         pcldc_pkg::PUMP_UNITY: begin
            if (!active) begin
               pump_d = pcldc_pkg::PUMP_OFF;
            end else if (!i_regulation_ok && qual_hit) begin
               pump_d = pcldc_pkg::PUMP_BOOST;
            end
         end
         pcldc_pkg::PUMP_BOOST: begin
            if (!active) begin
               pump_d = pcldc_pkg::PUMP_OFF;
            end
         end
         default: begin
            pump_d = pcldc_pkg::PUMP_OFF;
         end
      endcase
   end

   // Any regulated sample restarts the qualification window
   always_comb begin
      if (pump_q == pcldc_pkg::PUMP_UNITY && !i_regulation_ok && !qual_hit) begin
         qual_cnt_d = qual_cnt_q + 17'h00001;
      end else begin
         qual_cnt_d = '0;
      end
   end

   // Half periods of the pump clock; stopped outside boost
   always_comb begin
      sw_cnt_d   = '0;
      pump_clk_d = 1'b0;
      if (pump_q == pcldc_pkg::PUMP_BOOST) begin
         pump_clk_d = pump_clk_q ^ sw_hit;
         if (!sw_hit) begin
            sw_cnt_d = sw_cnt_q + 17'h00001;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         pump_q     <= pcldc_pkg::PUMP_OFF;
         qual_cnt_q <= '0;
         sw_cnt_q   <= '0;
         pump_clk_q <= 1'b0;
         boost_q    <= 1'b0;
      end else begin
         pump_q     <= pump_d;
         boost_q    <= (pump_d == pcldc_pkg::PUMP_BOOST);
         qual_cnt_q <= qual_cnt_d;
         sw_cnt_q   <= sw_cnt_d;
         pump_clk_q <= pump_clk_d;
      end
   end

   // Channel sinks: each tied pin dropped on its own
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         main_on_q <= '0;
         sub_on_q  <= '0;
      end else begin
         main_on_q <= {pcldc_pkg::MAIN_CH{active & (main_code_q != pcldc_pkg::CODE_OFF)}}
                      & ~i_main_tied;
         sub_on_q  <= {pcldc_pkg::SUB_CH{active & (sub_code_q != pcldc_pkg::CODE_OFF)}}
                      & ~i_sub_tied;
      end
   end

   assign o_main_code  = main_code_q;
   assign o_sub_code   = sub_code_q;
   assign o_main_on    = main_on_q;
   assign o_sub_on     = sub_on_q;
   assign o_pump_boost = boost_q;
   assign o_pump_clk   = pump_clk_q;
   assign o_shutdown   = shut_q;

endmodule

// ===== hw/pcldc_pkg.sv
/*
 Constants shared by both ends of the pulse-count LED dimming link.
 Assumes a single 50 MHz reference clock on each end.
*/
// Operation
// - Start pump in unity gain while regulating
// - Lost regulation for 400 us: boost gain
// - Pump start repeats on every shutdown exit
// - Main pulses set main group, sub sets sub
// - Host raises enable before any dimming pulse
// - First falling edge sets full scale 31 mA
// - Each further falling edge lowers 1 mA
// - 32nd pulse gives 0 mA, next 31 mA
// - Host spaces pulses by at least 300 ns
// - Pulse rates 5 kHz to 1 MHz accepted
// - Enable low 1.5 ms forces shutdown
// - Enable low: dimming edges are ignored
// - Channel tied to pump output is disabled
// - Thermal shutdown at hot, resume after cooling
// - Single wire drives enable and both dims
// - Single-wire low pulses shorter than 0.5 ms
// - Boost mode switches pump at 1 MHz
// - Enable rise: enabled with all currents zero
// - Undervoltage disables every LED channel
// - Shutdown puts every channel at zero current
package pcldc_pkg;
   localparam int CLK_PERIOD_NS = 20;
   // Times as printed, in nanoseconds
   localparam int T_OFF_NS      = 1500000;
   localparam int T_QUAL_NS     = 400000;
   localparam int T_SETUP_NS    = 10000;
   localparam int T_GAP_NS      = 300;
   localparam int T_LOW_NS      = 500;
   localparam int T_PUMP_HALF_NS = 500;
   localparam int T_SW_LOW_MAX_NS = 500000;
   // Least times round up, longest round down
   localparam int OFF_CYC       = (T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int QUAL_CYC      = (T_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC     = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CYC       = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_CYC       = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SW_LOW_MAX_CYC = T_SW_LOW_MAX_NS / CLK_PERIOD_NS;
   localparam int PUMP_HALF_CYC = T_PUMP_HALF_NS / CLK_PERIOD_NS;
   localparam int TIMER_W       = 17;
   localparam int CODE_W        = 5;
   localparam int MAIN_CH       = 4;
   localparam int SUB_CH        = 2;
   localparam logic [CODE_W-1:0] CODE_FULL = 5'h1F;
   localparam logic [CODE_W-1:0] CODE_OFF  = 5'h00;
   // Line bit positions: enable, main, sub
   localparam int LN_EN   = 0;
   localparam int LN_MAIN = 1;
   localparam int LN_SUB  = 2;
   localparam logic [2:0] LINE_IDLE = 3'h6;

   typedef enum logic [1:0] {
      PUMP_OFF   = 2'b00,
      PUMP_UNITY = 2'b01,
      PUMP_BOOST = 2'b10
   } pcldc_pump_t;

   typedef enum logic [1:0] {
      OP_ENABLE  = 2'b00,
      OP_DISABLE = 2'b01,
      OP_MAIN    = 2'b10,
      OP_SUB     = 2'b11
   } pcldc_op_t;

   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_LOW  = 2'b01,
      HS_WAIT = 2'b10
   } pcldc_hstate_t;
endpackage

// ===== hw/pcldc_if.sv
/*
 Wires between host and LED driver: enable and two dimming lines.
 Assumes both ends share no clock; the driver synchronises them.
*/
`timescale 1ns/1ps
interface pcldc_if;
   logic en;
   logic main_dim_pulse_n;
   logic sub_dim_pulse_n;
   modport host (output en, output main_dim_pulse_n, output sub_dim_pulse_n);
   modport dev  (input en, input main_dim_pulse_n, input sub_dim_pulse_n);
endinterface

// ===== hw/pcldc_host.sv
/*
 Host end: turns enable, disable and dimming-step requests into line
 waveforms with legal timing, on separate lines or one shared line.
 Assumes requests come from logic on the same clock.
*/
`timescale 1ns/1ps
module pcldc_host #(
   parameter int OFF_CYC   = pcldc_pkg::OFF_CYC,
   parameter int SETUP_CYC = pcldc_pkg::SETUP_CYC,
   parameter int LOW_CYC   = pcldc_pkg::LOW_CYC,
   parameter int GAP_CYC   = pcldc_pkg::GAP_CYC
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_srst,
   input  wire logic             i_single_wire,
   input  wire logic             i_req,
   input  wire logic [1:0]       i_req_op,
   output logic                  o_busy,
   output logic                  o_done,
   output logic                  o_refused,
   pcldc_if.host                 link
);

   pcldc_pkg::pcldc_hstate_t      st_q;
   pcldc_pkg::pcldc_hstate_t      st_d;
   logic [pcldc_pkg::TIMER_W-1:0] cnt_q;
   logic [pcldc_pkg::TIMER_W-1:0] cnt_d;
   logic                          en_q;
   logic                          en_d;
   logic                          main_n_q;
   logic                          main_n_d;
   logic                          sub_n_q;
   logic                          sub_n_d;
   logic                          done_q;
   logic                          done_d;
   logic                          ref_q;
   logic                          ref_d;
   logic                          busy_q;

   wire is_pulse = (i_req_op == pcldc_pkg::OP_MAIN) | (i_req_op == pcldc_pkg::OP_SUB);
   wire take     = i_req & (st_q == pcldc_pkg::HS_IDLE);
   wire cnt_zero = (cnt_q == '0);
   // Separate lines need enable high first; one wire is its own enable
   wire refuse   = take & is_pulse & ~en_q & ~i_single_wire;

   always_comb begin
      st_d     = st_q;
      cnt_d    = cnt_q;
      en_d     = en_q;
      main_n_d = main_n_q;
      sub_n_d  = sub_n_q;
      done_d   = 1'b0;
      ref_d    = refuse;
      unique case (st_q)
         pcldc_pkg::HS_IDLE: begin
            if (take && !refuse) begin
               unique case (i_req_op)
                  pcldc_pkg::OP_ENABLE: begin
                     en_d     = 1'b1;
                     main_n_d = 1'b1;
                     sub_n_d  = 1'b1;
                     cnt_d    = SETUP_CYC[pcldc_pkg::TIMER_W-1:0];
                     st_d     = pcldc_pkg::HS_WAIT;
                  end
                  pcldc_pkg::OP_DISABLE: begin
                     en_d     = 1'b0;
                     main_n_d = ~i_single_wire;
                     sub_n_d  = ~i_single_wire;
                     cnt_d    = OFF_CYC[pcldc_pkg::TIMER_W-1:0];
                     st_d     = pcldc_pkg::HS_WAIT;
                  end
                  default: begin
                     // Shared line: all three go low together, kept short
                     en_d     = en_q & ~i_single_wire;
                     main_n_d = ~(i_req_op == pcldc_pkg::OP_MAIN) & ~i_single_wire;
                     sub_n_d  = ~(i_req_op == pcldc_pkg::OP_SUB) & ~i_single_wire;
                     cnt_d    = LOW_CYC[pcldc_pkg::TIMER_W-1:0];
                     st_d     = pcldc_pkg::HS_LOW;
                  end
               endcase
            end
         end
         pcldc_pkg::HS_LOW: begin
            cnt_d = cnt_q - 17'h00001;
            if (cnt_zero) begin
               en_d     = 1'b1;
               main_n_d = 1'b1;
               sub_n_d  = 1'b1;
               cnt_d    = GAP_CYC[pcldc_pkg::TIMER_W-1:0];
               st_d     = pcldc_pkg::HS_WAIT;
            end
         end
         pcldc_pkg::HS_WAIT: begin
            cnt_d = cnt_q - 17'h00001;
            if (cnt_zero) begin
               cnt_d  = '0;
               done_d = 1'b1;
               st_d   = pcldc_pkg::HS_IDLE;
            end
         end
         default: begin
            st_d = pcldc_pkg::HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         st_q     <= pcldc_pkg::HS_IDLE;
         cnt_q    <= '0;
         en_q     <= 1'b0;
         main_n_q <= 1'b1;
         sub_n_q  <= 1'b1;
         done_q   <= 1'b0;
         ref_q    <= 1'b0;
         busy_q   <= 1'b0;
      end else begin
         busy_q   <= (st_d != pcldc_pkg::HS_IDLE);
         st_q     <= st_d;
         cnt_q    <= cnt_d;
         en_q     <= en_d;
         main_n_q <= main_n_d;
         sub_n_q  <= sub_n_d;
         done_q   <= done_d;
         ref_q    <= ref_d;
      end
   end

   assign o_busy                = busy_q;
   assign o_done                = done_q;
   assign o_refused             = ref_q;
   assign link.en               = en_q;
   assign link.main_dim_pulse_n = main_n_q;
   assign link.sub_dim_pulse_n  = sub_n_q;

endmodule

// ===== dv/pcldc_sva.sv
/*
 Concurrent checks on the link of the first host and driver pair.
 Assumes the bench wires it beside that link and the driver outputs.
*/
`timescale 1ns/1ps
module pcldc_sva #(
   parameter int OFF_CYC       = pcldc_pkg::OFF_CYC,
   parameter int QUAL_CYC      = pcldc_pkg::QUAL_CYC,
   parameter int PUMP_HALF_CYC = pcldc_pkg::PUMP_HALF_CYC
) (
   input wire logic                          i_ref_clk,
   input wire logic                          i_srst,
   input wire logic                          en,
   input wire logic                          main_dim_pulse_n,
   input wire logic                          sub_dim_pulse_n,
   input wire logic                          i_regulation_ok,
   input wire logic [pcldc_pkg::CODE_W-1:0]  o_main_code,
   input wire logic [pcldc_pkg::CODE_W-1:0]  o_sub_code,
   input wire logic [pcldc_pkg::MAIN_CH-1:0] o_main_on,
   input wire logic [pcldc_pkg::SUB_CH-1:0]  o_sub_on,
   input wire logic                          o_pump_boost,
   input wire logic                          o_pump_clk,
   input wire logic                          o_shutdown
);
   logic [17:0] en_low_q;
   logic [17:0] reg_low_q;
   logic [7:0]  run_q;
   logic        pclk_prev_q;
   wire         pclk_edge = o_pump_clk != pclk_prev_q;

   // Run lengths of enable low, lost regulation and pump clock level
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         en_low_q    <= 18'h0;
         reg_low_q   <= 18'h0;
         run_q       <= 8'h0;
         pclk_prev_q <= 1'b0;
      end else begin
         en_low_q    <= en ? 18'h0 : en_low_q + 18'h1;
         reg_low_q   <= i_regulation_ok ? 18'h0 : reg_low_q + 18'h1;
         run_q       <= pclk_edge ? 8'h1 : (run_q == 8'hFF ? run_q : run_q + 8'h1);
         pclk_prev_q <= o_pump_clk;
      end
   end

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_srst);

   property p_step(logic [4:0] code);
      $changed(code) && !o_shutdown |-> code == (($past(code) == 5'h00) ? 5'h1F : $past(code) - 5'h01);
   endproperty

   // A code may only move within six cycles of a change on its line
   property p_quiet(logic line, logic [4:0] code);
      $stable(line) [*6] ##0 !o_shutdown |-> $stable(code);
   endproperty

   chk_main_step_order: assert property (p_step(o_main_code)) else $error("main code step wrong");
   chk_sub_step_order: assert property (p_step(o_sub_code)) else $error("sub code step wrong");
   chk_main_code_quiet: assert property (p_quiet(main_dim_pulse_n, o_main_code)) else $error("main code moved");
   chk_sub_code_quiet: assert property (p_quiet(sub_dim_pulse_n, o_sub_code)) else $error("sub code moved");
   chk_shutdown_late: assert property (en_low_q == OFF_CYC + 8 |-> o_shutdown) else $error("no shutdown");
   chk_shutdown_early: assert property ($rose(o_shutdown) |-> en_low_q >= OFF_CYC) else $error("early shutdown");
   chk_shutdown_clears: assert property (o_shutdown [*3] |-> o_main_code == 5'h00 && o_sub_code == 5'h00
      && o_main_on == 4'h0 && o_sub_on == 2'h0) else $error("shutdown left current");
   chk_wake_zero: assert property ($fell(o_shutdown) |-> o_main_code == 5'h00 && o_sub_code == 5'h00)
      else $error("wake not at zero");
   chk_wake_unity: assert property ($fell(o_shutdown) |-> !o_pump_boost [*8]) else $error("wake not unity");
   chk_boost_qual: assert property ($rose(o_pump_boost) |-> reg_low_q >= QUAL_CYC)
      else $error("boost too soon");
   chk_pump_clk_idle: assert property (!o_pump_boost && !$past(o_pump_boost) |-> !o_pump_clk)
      else $error("pump clock outside boost");
   chk_pump_half_len: assert property (o_pump_boost && $past(o_pump_boost, 40) && pclk_edge
      |-> run_q == PUMP_HALF_CYC) else $error("pump half period wrong");

   cov_boost: cover property ($rose(o_pump_boost));
   cov_wake: cover property ($fell(o_shutdown));
   cov_wrap: cover property ($changed(o_main_code) && o_main_code == 5'h1F && $past(o_main_code) == 5'h00);
endmodule

// ===== dv/pcldc_tb_top.sv
/*
 Self-checking bench: host and driver joined by one link, plus a second
 driver whose link the bench drives directly to break the enable order.
 Assumes a 50 MHz clock and shortened shutdown and qualify counts.
*/
`timescale 1ns/1ps
module pcldc_tb_top;
   localparam int OFF   = 200;
   localparam int QUAL  = 50;
   localparam int LIMIT = 40000;
   logic       i_ref_clk       = 1'b0;
   logic       i_srst          = 1'b1;
   logic       i_single_wire   = 1'b0;
   logic       i_req           = 1'b0;
   logic [1:0] i_req_op        = 2'h0;
   logic       i_regulation_ok = 1'b1;
   logic       i_die_hot       = 1'b0;
   logic       i_die_cooled    = 1'b1;
   logic       i_uvlo          = 1'b0;
   logic [3:0] i_main_tied     = 4'h0;
   logic [1:0] i_sub_tied      = 2'h0;
   logic       o_busy;
   logic       o_done;
   logic       o_refused;
   logic [4:0] o_main_code;
   logic [4:0] o_sub_code;
   logic [3:0] o_main_on;
   logic [1:0] o_sub_on;
   logic       o_pump_boost;
   logic       o_pump_clk;
   logic       o_shutdown;
   logic [4:0] b_main_code;
   logic [4:0] exp_m = 5'h00;
   logic [4:0] exp_s = 5'h00;
   logic       r;
   logic       p;
   int         i;
   int         t;
   int         cycles   = 0;
   int         failures = 0;
   int         compares = 0;

   always #10 i_ref_clk = ~i_ref_clk;

   pcldc_if u_if ();
   pcldc_if u_if_b ();

   pcldc_host #(.OFF_CYC(OFF), .SETUP_CYC(20)) u_pcldc_host (
      .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_single_wire(i_single_wire), .i_req(i_req),
      .i_req_op(i_req_op), .o_busy(o_busy), .o_done(o_done), .o_refused(o_refused), .link(u_if));

   pcldc_dev #(.OFF_CYC(OFF), .QUAL_CYC(QUAL)) u_pcldc_dev (
      .i_ref_clk(i_ref_clk), .i_srst(i_srst), .link(u_if), .i_regulation_ok(i_regulation_ok),
      .i_die_hot(i_die_hot), .i_die_cooled(i_die_cooled), .i_uvlo(i_uvlo), .i_main_tied(i_main_tied),
      .i_sub_tied(i_sub_tied), .o_main_code(o_main_code), .o_sub_code(o_sub_code), .o_main_on(o_main_on),
      .o_sub_on(o_sub_on), .o_pump_boost(o_pump_boost), .o_pump_clk(o_pump_clk), .o_shutdown(o_shutdown));

   // Second driver: bench plays a host that ignores the enable order
   pcldc_dev #(.OFF_CYC(OFF), .QUAL_CYC(QUAL)) u_pcldc_dev_b (
      .i_ref_clk(i_ref_clk), .i_srst(i_srst), .link(u_if_b), .i_regulation_ok(i_regulation_ok),
      .i_die_hot(i_die_hot), .i_die_cooled(i_die_cooled), .i_uvlo(i_uvlo), .i_main_tied(i_main_tied),
      .i_sub_tied(i_sub_tied), .o_main_code(b_main_code), .o_sub_code(), .o_main_on(), .o_sub_on(),
      .o_pump_boost(), .o_pump_clk(), .o_shutdown());

   pcldc_sva #(.OFF_CYC(OFF), .QUAL_CYC(QUAL)) u_pcldc_sva (
      .i_ref_clk(i_ref_clk), .i_srst(i_srst), .en(u_if.en), .main_dim_pulse_n(u_if.main_dim_pulse_n),
      .sub_dim_pulse_n(u_if.sub_dim_pulse_n), .i_regulation_ok(i_regulation_ok), .o_main_code(o_main_code),
      .o_sub_code(o_sub_code), .o_main_on(o_main_on), .o_sub_on(o_sub_on), .o_pump_boost(o_pump_boost),
      .o_pump_clk(o_pump_clk), .o_shutdown(o_shutdown));

   task automatic test_done;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [4:0] nxt(input logic [4:0] c);
      return (c == 5'h00) ? 5'h1F : c - 5'h01;
   endfunction

   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask

   // Tied pins are re-drawn with every request
   task automatic do_op(input logic [1:0] op, output logic refused);
      int n;
      @(posedge i_ref_clk);
      i_req       <= 1'b1;
      i_req_op    <= op;
      i_main_tied <= 4'($urandom);
      i_sub_tied  <= 2'($urandom);
      @(posedge i_ref_clk);
      i_req <= 1'b0;
      n = 0;
      // Refusal stands only in the cycle right after the take edge
      #1;
      while (!(o_done || o_refused) && n < 2000) begin
         wait_clk(1);
         n++;
      end
      refused = o_refused;
      check(16'(n < 2000), 16'h1);
      check(o_busy, 1'b0);
   endtask

   task automatic expect_state;
      wait_clk(3);
      check({o_main_code, o_sub_code}, {exp_m, exp_s});
      check({o_main_on, o_sub_on}, {(exp_m != 5'h00) ? ~i_main_tied : 4'h0,
                                    (exp_s != 5'h00) ? ~i_sub_tied : 2'h0});
   endtask

   task automatic step(input logic grp);
      logic rr;
      do_op(grp ? 2'h3 : 2'h2, rr);
      if (i_single_wire || !grp) exp_m = nxt(exp_m);
      if (i_single_wire || grp) exp_s = nxt(exp_s);
      expect_state();
   endtask

   task automatic pulse_b;
      @(posedge i_ref_clk);
      u_if_b.main_dim_pulse_n <= 1'b0;
      repeat (20) @(posedge i_ref_clk);
      u_if_b.main_dim_pulse_n <= 1'b1;
      wait_clk(20);
   endtask

   task automatic power_cycle;
      do_op(2'h1, r);
      wait_clk(6);
      exp_m = 5'h00;
      exp_s = 5'h00;
      check(o_shutdown, 1'b1);
      expect_state();
      do_op(2'h0, r);
      wait_clk(4);
      check({o_shutdown, o_pump_boost}, 2'h0);
   endtask

   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         test_done();
      end
   end

   initial begin
      void'($urandom(32'hB8EA));
      u_if_b.en               = 1'b0;
      u_if_b.main_dim_pulse_n = 1'b1;
      u_if_b.sub_dim_pulse_n  = 1'b1;
      repeat (12) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      do_op(2'h2, r);
      check(r, 1'b1);
      check(o_shutdown, 1'b1);
      expect_state();
      do_op(2'h0, r);
      wait_clk(4);
      check({o_shutdown, o_pump_boost}, 2'h0);
      expect_state();
      for (i = 0; i < 33; i++) step(1'b0);
      for (i = 0; i < 33; i++) step(1'b1);
      repeat (30) step(1'($urandom_range(0, 1)));
      @(posedge i_ref_clk);
      i_regulation_ok <= 1'b0;
      wait_clk(QUAL - 4);
      check(o_pump_boost, 1'b0);
      wait_clk(8);
      check(o_pump_boost, 1'b1);
      p = o_pump_clk;
      t = 0;
      repeat (250) begin
         wait_clk(1);
         t += int'(o_pump_clk !== p);
         p = o_pump_clk;
      end
      check(16'(t >= 9 && t <= 11), 16'h1);
      i_regulation_ok <= 1'b1;
      i_die_hot       <= 1'b1;
      i_die_cooled    <= 1'b0;
      wait_clk(6);
      check({o_main_on, o_sub_on, o_pump_boost}, 7'h00);
      i_die_hot <= 1'b0;
      wait_clk(6);
      check({o_main_on, o_sub_on}, 6'h00);
      i_die_cooled <= 1'b1;
      expect_state();
      check(o_pump_boost, 1'b0);
      i_uvlo <= 1'b1;
      wait_clk(6);
      check({o_main_on, o_sub_on}, 6'h00);
      i_uvlo <= 1'b0;
      power_cycle();
      step(1'b0);
      i_single_wire <= 1'b1;
      power_cycle();
      step(1'b0);
      step(1'b0);
      check(o_shutdown, 1'b0);
      do_op(2'h1, r);
      wait_clk(6);
      check(o_shutdown, 1'b1);
      repeat (2) pulse_b();
      check(b_main_code, 5'h00);
      u_if_b.en <= 1'b1;
      wait_clk(20);
      pulse_b();
      check(b_main_code, 5'h1F);
      u_if_b.en <= 1'b0;
      wait_clk(5);
      pulse_b();
      check(b_main_code, 5'h1F);
      u_if_b.en <= 1'b1;
      wait_clk(10);
      pulse_b();
      check(b_main_code, 5'h1E);
      test_done();
   end
endmodule
